// ===== rtl/opcode_operand_decoder.sv
// byte-serial instruction decoder with operand descriptors
`timescale 1ns/1ps
`default_nettype none
`include "opdec_cfg.svh"

module opcode_operand_decoder
  import opdec_pkg::*;
(
  input  wire logic                i_sys_clk,
  input  wire logic                i_rst,
  input  wire logic                i_byte_valid,
  input  wire logic [7:0]          i_byte,
  input  wire logic                i_op_size32,
  input  wire logic                i_addr_size32,
  input  wire operand_code_t       i_op_code,
  input  wire logic [2:0]          i_imm_len,
  output logic                     o_byte_ready,
  output logic                     o_dec_valid,
  output opdec_pkg::decoded_t      o_dec,
  output opdec_pkg::operand_desc_t o_opnd
);
  import opdec_pkg::*;

  // ==========================================================
  // collection state machine
  typedef enum logic [2:0] {
    S_OPC, S_OPC2, S_SPEC, S_DISP, S_IMM, S_DONE
  } state_t;
  state_t        state_q;
  decoded_t      dec_q;
  logic [2:0]    cnt_q;
  operand_code_t code_q;
  logic          size32_q;
  logic          addr32_q;

  logic take;
  assign take = i_byte_valid && o_byte_ready;

  // methods that need a specifier byte
  function automatic logic needs_spec(input addr_method_t m);
    unique case (m)
      AM_CTRL, AM_DEBUG, AM_RM, AM_GEN, AM_MEM, AM_REGONLY, AM_SEG,
      AM_TEST: needs_spec = 1'b1;
      default: needs_spec = 1'b0;
    endcase
  endfunction : needs_spec

  // displacement length from specifier and address size
  function automatic logic [2:0] disp_bytes(input logic [7:0] s,
                                            input logic a32);
    logic [1:0] md;
    md = s[`OPD_MOD_HI:`OPD_MOD_LO];
    if (md == 2'b11) disp_bytes = 3'd0;
    else if (md == 2'b01) disp_bytes = 3'd1;
    else if (md == 2'b10) disp_bytes = a32 ? 3'd4 : 3'd2;
    else if (a32 && s[`OPD_RM_HI:`OPD_RM_LO] == `OPD_RM_DISP32)
      disp_bytes = 3'd4;
    else if (!a32 && s[`OPD_RM_HI:`OPD_RM_LO] == 3'h6)
      disp_bytes = 3'd2;
    else disp_bytes = 3'd0;
  endfunction : disp_bytes

  function automatic logic is_float(input logic [7:0] b);
    is_float = (b & `OPD_FPU_MASK) == `OPD_FPU_LO;
  endfunction : is_float

  logic [2:0] dlen_n;
  assign dlen_n = disp_bytes(i_byte, addr32_q);

  // ==========================================================
  // byte collection
  always_ff @(posedge i_sys_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      state_q  <= S_OPC;
      dec_q    <= '0;
      cnt_q    <= 3'd0;
      code_q   <= '0;
      size32_q <= 1'b0;
      addr32_q <= 1'b0;
    end
    else
    begin
      unique case (state_q)
        S_OPC:
          if (take)
          begin
            dec_q        <= '0;
            dec_q.opcode <= i_byte;
            dec_q.row    <= i_byte[7:4];
            dec_q.col    <= i_byte[3:0];
            code_q       <= i_op_code;
            size32_q     <= i_op_size32;
            addr32_q     <= i_addr_size32;
            dec_q.imm_len <= i_imm_len;
            dec_q.float_page <= is_float(i_byte);
            if (i_byte == `OPD_ESC2)
              state_q <= S_OPC2;
            else if (is_float(i_byte) || needs_spec(i_op_code.method))
              state_q <= S_SPEC;
            else if (i_op_code.method == AM_DIRECT
                     || i_op_code.method == AM_MOFS)
            begin
              dec_q.disp_len <= i_addr_size32 ? 3'd4 : 3'd2;
              cnt_q   <= 3'd0;
              state_q <= S_DISP;
            end
            else if (i_imm_len != 3'd0)
            begin
              cnt_q   <= 3'd0;
              state_q <= S_IMM;
            end
            else
              state_q <= S_DONE;
          end
        S_OPC2:
          if (take)
          begin
            dec_q.two_byte <= 1'b1;
            dec_q.opcode   <= i_byte;
            dec_q.row      <= i_byte[7:4];
            dec_q.col      <= i_byte[3:0];
            code_q         <= i_op_code;
            dec_q.imm_len  <= i_imm_len;
            if (needs_spec(i_op_code.method))
              state_q <= S_SPEC;
            else if (i_op_code.method == AM_DIRECT
                     || i_op_code.method == AM_MOFS)
            begin
              // address size was latched with the escape byte
              dec_q.disp_len <= addr32_q ? 3'd4 : 3'd2;
              cnt_q   <= 3'd0;
              state_q <= S_DISP;
            end
            else if (i_imm_len != 3'd0)
            begin
              cnt_q   <= 3'd0;
              state_q <= S_IMM;
            end
            else
              state_q <= S_DONE;
          end
        S_SPEC:
          if (take)
          begin
            dec_q.has_spec <= 1'b1;
            dec_q.spec     <= i_byte;
            dec_q.ext      <= i_byte[`OPD_REG_HI:`OPD_REG_LO];
            if (dec_q.float_page && i_byte > `OPD_FPU_SPEC_MAX)
            begin
              dec_q.float_table <= 1'b1;
              dec_q.row <= i_byte[7:4];
              dec_q.col <= i_byte[3:0];
            end
            dec_q.illegal <= code_q.method == AM_MEM
                             && i_byte[7:6] == 2'b11;
            if (code_q.method == AM_REGONLY || dlen_n == 3'd0)
            begin
              dec_q.disp_len <= 3'd0;
              cnt_q <= 3'd0;
              state_q <= dec_q.imm_len != 3'd0 ? S_IMM : S_DONE;
            end
            else
            begin
              dec_q.disp_len <= dlen_n;
              cnt_q <= 3'd0;
              state_q <= S_DISP;
            end
          end
        S_DISP:
          if (take)
          begin
            dec_q.disp[cnt_q*8 +: 8] <= i_byte; // little-endian
            cnt_q <= cnt_q + 3'd1;
            if (cnt_q + 3'd1 == dec_q.disp_len)
            begin
              cnt_q   <= 3'd0;
              state_q <= dec_q.imm_len != 3'd0 ? S_IMM : S_DONE;
            end
          end
        S_IMM:
          if (take)
          begin
            dec_q.imm[cnt_q*8 +: 8] <= i_byte;
            cnt_q <= cnt_q + 3'd1;
            if (cnt_q + 3'd1 == dec_q.imm_len)
              state_q <= S_DONE;
          end
        S_DONE:
          state_q <= S_OPC;
        default:
          state_q <= S_OPC;
      endcase
    end
  end

  // ==========================================================
  // operand descriptor, resolved from stored codes
  operand_desc_t opnd_d;
  always_comb
  begin
    opnd_d = '0;
    opnd_d.code = code_q;
    unique case (code_q.otype)
      OT_BYTE:         opnd_d.size_bytes = 7'd1;
      OT_WORD:         opnd_d.size_bytes = 7'd2;
      OT_DWORD:        opnd_d.size_bytes = 7'd4;
      OT_QWORD:        opnd_d.size_bytes = 7'd8;
      OT_PSEUDO_DESC:  opnd_d.size_bytes = 7'd6;
      OT_VAR:          opnd_d.size_bytes = size32_q ? 7'd4 : 7'd2;
      OT_BYTE_WORD:    opnd_d.size_bytes = size32_q ? 7'd2 : 7'd1;
      OT_PTR:          opnd_d.size_bytes = size32_q ? 7'd6 : 7'd4;
      OT_BOUND:        opnd_d.size_bytes = size32_q ? 7'd8 : 7'd4;
      default:         opnd_d.size_bytes = 7'd0;
    endcase
    opnd_d.reg_index = dec_q.spec[`OPD_REG_HI:`OPD_REG_LO];
    unique case (code_q.method)
      AM_CTRL:  opnd_d.reg_file = RF_CTRL;
      AM_DEBUG: opnd_d.reg_file = RF_DEBUG;
      AM_TEST:  opnd_d.reg_file = RF_TEST;
      AM_SEG:   opnd_d.reg_file = RF_SEG;
      AM_GEN:   opnd_d.reg_file = RF_GEN;
      AM_REGONLY:
      begin
        opnd_d.reg_file  = RF_GEN;
        opnd_d.reg_index = dec_q.spec[`OPD_RM_HI:`OPD_RM_LO];
      end
      AM_RM, AM_MEM:
      begin
        opnd_d.is_memory = dec_q.spec[7:6] != 2'b11;
        opnd_d.reg_file  = opnd_d.is_memory ? RF_NONE : RF_GEN;
        opnd_d.reg_index = dec_q.spec[`OPD_RM_HI:`OPD_RM_LO];
        opnd_d.no_base_index = addr32_q && dec_q.spec[7:6] == 2'b00
          && dec_q.spec[2:0] == `OPD_RM_DISP32;
      end
      AM_DIRECT, AM_MOFS:
      begin
        opnd_d.is_memory     = 1'b1;
        opnd_d.no_base_index = 1'b1;
      end
      AM_STR_SRC:
      begin
        opnd_d.is_memory = 1'b1;
        opnd_d.seg       = SEG_DATA;
        opnd_d.index_si  = 1'b1;
      end
      AM_STR_DST:
      begin
        opnd_d.is_memory = 1'b1;
        opnd_d.seg       = SEG_EXTRA;
        opnd_d.index_di  = 1'b1;
      end
      default: opnd_d.reg_file = RF_NONE;
    endcase
  end

  // ==========================================================
  // registered outputs
  always_ff @(posedge i_sys_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      o_dec_valid  <= 1'b0;
      o_dec        <= '0;
      o_opnd       <= '0;
      o_byte_ready <= 1'b0;
    end
    else
    begin
      o_dec_valid  <= state_q == S_DONE;
      o_byte_ready <= 1'b1;
      if (state_q == S_DONE)
      begin
        o_dec  <= dec_q; // imm/disp carry the raw bytes, zero-filled above their length
        o_opnd <= opnd_d;
      end
    end
  end

  // ==========================================================
  // checks
  property p_valid_one;
    @(posedge i_sys_clk) disable iff (i_rst)
      o_dec_valid |=> !o_dec_valid;
  endproperty
  a_valid_one: assert property (p_valid_one)
    else $error("decoded valid held two cycles");

  property p_esc2;
    @(posedge i_sys_clk) disable iff (i_rst)
      state_q == S_OPC && take && i_byte == `OPD_ESC2 |=> state_q == S_OPC2;
  endproperty
  a_esc2: assert property (p_esc2)
    else $error("escape byte not followed by second opcode");

  property p_row_col;
    @(posedge i_sys_clk) disable iff (i_rst)
      o_dec_valid && !o_dec.float_table |-> o_dec.row == o_dec.opcode[7:4]
        && o_dec.col == o_dec.opcode[3:0];
  endproperty
  a_row_col: assert property (p_row_col)
    else $error("row or column not from opcode nibbles");

  property p_float_hi;
    @(posedge i_sys_clk) disable iff (i_rst)
      o_dec_valid && o_dec.float_page && o_dec.has_spec
        |-> o_dec.float_table == (o_dec.spec > `OPD_FPU_SPEC_MAX);
  endproperty
  a_float_hi: assert property (p_float_hi)
    else $error("float table choice wrong");

  property p_ext;
    @(posedge i_sys_clk) disable iff (i_rst)
      o_dec_valid && o_dec.has_spec |-> o_dec.ext == o_dec.spec[5:3];
  endproperty
  a_ext: assert property (p_ext)
    else $error("extension field wrong");

  property p_disp32;
    @(posedge i_sys_clk) disable iff (i_rst)
      state_q == S_SPEC && take && addr32_q && i_byte == 8'h05
        && code_q.method == AM_RM |=> dec_q.disp_len == 3'd4;
  endproperty
  a_disp32: assert property (p_disp32)
    else $error("disp32 form not expected");

  property p_var_size;
    @(posedge i_sys_clk) disable iff (i_rst)
      o_dec_valid && o_opnd.code.otype == OT_VAR
        |-> o_opnd.size_bytes == 7'd2 || o_opnd.size_bytes == 7'd4;
  endproperty
  a_var_size: assert property (p_var_size)
    else $error("variable size out of range");

  property p_mem_only;
    @(posedge i_sys_clk) disable iff (i_rst)
      o_dec_valid && o_opnd.code.method == AM_MEM && o_dec.spec[7:6] == 2'b11
        |-> o_dec.illegal;
  endproperty
  a_mem_only: assert property (p_mem_only)
    else $error("register form accepted for memory-only");

  c_two_byte: cover property (@(posedge i_sys_clk) o_dec_valid
    && o_dec.two_byte);
  c_float_tbl: cover property (@(posedge i_sys_clk) o_dec_valid
    && o_dec.float_table);
  c_imm: cover property (@(posedge i_sys_clk) o_dec_valid
    && o_dec.imm_len != 3'd0 && o_dec.disp_len != 3'd0);
endmodule : opcode_operand_decoder
`default_nettype wire

// ===== rtl/opdec_cfg.svh
// constants for the opcode and operand decoder
`ifndef OPDEC_CFG_SVH
`define OPDEC_CFG_SVH
`define OPD_ESC2         8'h0F
`define OPD_FPU_LO       8'hD8
`define OPD_FPU_MASK     8'hF8
`define OPD_FPU_SPEC_MAX 8'hBF
`define OPD_MOD_HI       7
`define OPD_MOD_LO       6
`define OPD_REG_HI       5
`define OPD_REG_LO       3
`define OPD_RM_HI        2
`define OPD_RM_LO        0
`define OPD_RM_DISP32    3'h5
`define OPD_RM_SIB       3'h4
`define OPD_REG_ACC      3'h0
`endif

// ===== rtl/opdec_pkg.sv
// types for the opcode and operand decoder
package opdec_pkg;
  typedef enum logic [3:0] {
    AM_NONE, AM_DIRECT, AM_CTRL, AM_DEBUG, AM_RM, AM_FLAGS, AM_GEN,
    AM_IMM, AM_REL, AM_MEM, AM_MOFS, AM_REGONLY, AM_SEG, AM_TEST,
    AM_STR_SRC, AM_STR_DST
  } addr_method_t;
  typedef enum logic [3:0] {
    OT_NONE, OT_BOUND, OT_BYTE, OT_BYTE_WORD, OT_DWORD, OT_PTR,
    OT_QWORD, OT_PSEUDO_DESC, OT_VAR, OT_WORD
  } op_type_t;
  typedef enum logic [2:0] {
    RF_NONE, RF_GEN, RF_CTRL, RF_DEBUG, RF_TEST, RF_SEG
  } reg_file_t;
  typedef enum logic [1:0] {
    SEG_NONE, SEG_DATA, SEG_EXTRA
  } seg_sel_t;
  typedef struct packed {
    addr_method_t method;
    op_type_t     otype;
  } operand_code_t;
  typedef struct packed {
    operand_code_t code;
    logic [6:0]    size_bytes;
    reg_file_t     reg_file;
    logic [2:0]    reg_index;
    logic          is_memory;
    logic          no_base_index;
    seg_sel_t      seg;
    logic          index_si;
    logic          index_di;
  } operand_desc_t;
  typedef struct packed {
    logic       two_byte;
    logic       float_page;
    logic       float_table;
    logic [7:0] opcode;
    logic [3:0] row;
    logic [3:0] col;
    logic [2:0] ext;
    logic       has_spec;
    logic [7:0] spec;
    logic [2:0] disp_len;
    logic [31:0] disp;
    logic [2:0] imm_len;
    logic [31:0] imm;
    logic       illegal;
  } decoded_t;
endpackage : opdec_pkg

// ===== verif/fetch_model.sv
// fetch unit model offering instruction bytes to the decoder
`timescale 1ns/1ps
`default_nettype none
module fetch_model
(
  input  wire logic  i_sys_clk,
  input  wire logic  i_ready,
  output logic       o_valid,
  output logic [7:0] o_byte
);
  logic [8:0] q[$];
  logic       taken;
  int         gap;
  int         wait_n;
  initial
  begin
    o_valid = 1'b0;
    o_byte  = 8'h00;
    gap     = 0;
    wait_n  = 0;
  end
  task automatic send(input logic [7:0] b[$]);
    foreach (b[i])
      q.push_back({i == b.size() - 1, b[i]});
  endtask : send
  // =====================================
  // byte offer, held until taken
  always @(posedge i_sys_clk)
    taken <= o_valid && i_ready;
  always @(negedge i_sys_clk)
  begin
    if (taken)
    begin
      wait_n = q[0][8] ? gap + 1 : gap;
      void'(q.pop_front());
    end
    if (taken || !o_valid)
    begin
      if (q.size() != 0 && wait_n == 0)
      begin
        o_valid = 1'b1;
        o_byte  = q[0][7:0];
      end
      else
      begin
        o_valid = 1'b0;
        o_byte  = ~o_byte;
        if (wait_n != 0)
          wait_n--;
      end
    end
  end
endmodule : fetch_model
`default_nettype wire

// ===== verif/testbench.sv
// self-checking bench for the opcode and operand decoder
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import opdec_pkg::*;
  logic          i_sys_clk;
  logic          i_rst;
  logic          i_byte_valid;
  logic [7:0]    i_byte;
  logic          i_op_size32;
  logic          i_addr_size32;
  operand_code_t i_op_code;
  logic [2:0]    i_imm_len;
  logic          o_byte_ready;
  logic          o_dec_valid;
  decoded_t      o_dec;
  operand_desc_t o_opnd;
  int            mismatches;
  int            checks_done;
  int            seed;
  int            n;
  logic [31:0]   rnd;
  logic [7:0]    op;
  logic [7:0]    b[$];
  opcode_operand_decoder opcode_operand_decoder_inst
  (
    .i_sys_clk     (i_sys_clk),
    .i_rst         (i_rst),
    .i_byte_valid  (i_byte_valid),
    .i_byte        (i_byte),
    .i_op_size32   (i_op_size32),
    .i_addr_size32 (i_addr_size32),
    .i_op_code     (i_op_code),
    .i_imm_len     (i_imm_len),
    .o_byte_ready  (o_byte_ready),
    .o_dec_valid   (o_dec_valid),
    .o_dec         (o_dec),
    .o_opnd        (o_opnd)
  );
  fetch_model fetch_model_inst
  (
    .i_sys_clk (i_sys_clk),
    .i_ready   (o_byte_ready),
    .o_valid   (i_byte_valid),
    .o_byte    (i_byte)
  );
  always #5 i_sys_clk = ~i_sys_clk;
  // =====================================
  // checking helpers
  task automatic ck(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      mismatches++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : ck
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : end_of_test
  function automatic logic hspec(input logic [7:0] o, input addr_method_t m);
    return (o & 8'hF8) == 8'hD8 || m inside {AM_CTRL, AM_DEBUG, AM_RM,
      AM_GEN, AM_MEM, AM_REGONLY, AM_SEG, AM_TEST};
  endfunction : hspec
  function automatic int dlen(input logic [7:0] s, input logic hs,
                              input addr_method_t m, input logic a32);
    if (!hs)
      return (m == AM_DIRECT || m == AM_MOFS) ? (a32 ? 4 : 2) : 0;
    // register-only ignores mod, so never a displacement
    if (m == AM_REGONLY)
      return 0;
    case (s[7:6])
      2'b00:   return (s[2:0] == (a32 ? 3'h5 : 3'h6)) ? (a32 ? 4 : 2) : 0;
      2'b01:   return 1;
      2'b10:   return a32 ? 4 : 2;
      default: return 0;
    endcase
  endfunction : dlen
  function automatic logic [6:0] sz(input op_type_t t, input logic w);
    case (t)
      OT_BYTE:        return 7'h01;
      OT_WORD:        return 7'h02;
      OT_DWORD:       return 7'h04;
      OT_QWORD:       return 7'h08;
      OT_PSEUDO_DESC: return 7'h06;
      OT_BYTE_WORD:   return w ? 7'h02 : 7'h01;
      OT_VAR:         return w ? 7'h04 : 7'h02;
      OT_PTR:         return w ? 7'h06 : 7'h04;
      OT_BOUND:       return w ? 7'h08 : 7'h04;
      default:        return 7'h00;
    endcase
  endfunction : sz
  task automatic run(input logic [7:0] ib[$], input addr_method_t m,
                     input op_type_t t, input logic [2:0] il,
                     input logic a32, input logic w);
    int            p;
    int            dl;
    logic          hs;
    logic          fl;
    logic [7:0]    o;
    logic [7:0]    s;
    logic [31:0]   dv;
    logic [31:0]   iv;
    operand_desc_t d;
    @(negedge i_sys_clk);
    i_op_code     = '{m, t};
    i_imm_len     = il;
    i_addr_size32 = a32;
    i_op_size32   = w;
    fetch_model_inst.send(ib);
    p  = (ib[0] == 8'h0F) ? 2 : 1;
    o  = ib[p-1];
    fl = (ib[0] & 8'hF8) == 8'hD8;
    hs = hspec(ib[0], m);
    s  = hs ? ib[p] : 8'h00;
    p  = p + int'(hs);
    dl = dlen(s, hs, m, a32);
    dv = '0;
    iv = '0;
    for (int i = 0; i < dl; i++)
      dv[8*i +: 8] = ib[p + i];
    for (int i = 0; i < il; i++)
      iv[8*i +: 8] = ib[p + dl + i];
    repeat (100)
    begin
      @(posedge i_sys_clk);
      #1;
      if (o_dec_valid === 1'b1)
        break;
    end
    d = o_opnd;
    ck(32'(o_dec_valid), 1);
    ck(fetch_model_inst.q.size(), 0);
    ck(32'(o_dec.two_byte), 32'(ib[0] == 8'h0F));
    ck(32'(o_dec.float_table), 32'(fl && s > 8'hBF));
    if (!fl || s > 8'hBF)
      ck(32'({o_dec.row, o_dec.col}), 32'(fl ? s : o));
    if (hs)
      ck(32'(o_dec.ext), 32'(s[5:3]));
    ck(32'({o_dec.has_spec, o_dec.disp_len}), 32'({hs, 3'(dl)}));
    ck(o_dec.disp, dv);
    ck(32'(o_dec.imm_len), 32'(il));
    ck(o_dec.imm, iv);
    ck(32'(o_dec.illegal), 32'(m == AM_MEM && s[7:6] == 2'b11));
    ck(32'(d.code), 32'({m, t}));
    ck(32'(d.size_bytes), 32'(sz(t, w)));
    case (m)
      AM_CTRL:    ck(32'(d.reg_file), 32'(RF_CTRL));
      AM_DEBUG:   ck(32'(d.reg_file), 32'(RF_DEBUG));
      AM_TEST:    ck(32'(d.reg_file), 32'(RF_TEST));
      AM_SEG:     ck(32'(d.reg_file), 32'(RF_SEG));
      AM_GEN:     ck(32'({d.reg_file, d.reg_index}), 32'({RF_GEN, s[5:3]}));
      AM_REGONLY: ck(32'({d.reg_file, d.is_memory}), 32'({RF_GEN, 1'b0}));
      AM_RM:      ck(32'(d.is_memory), 32'(s[7:6] != 2'b11));
      AM_DIRECT:  ck(32'(d.no_base_index), 1);
      AM_MOFS:    ck(32'(d.no_base_index), 1);
      AM_STR_SRC: ck(32'({d.seg, d.index_si}), 32'({SEG_DATA, 1'b1}));
      AM_STR_DST: ck(32'({d.seg, d.index_di}), 32'({SEG_EXTRA, 1'b1}));
      default:    ;
    endcase
    if (m == AM_RM && a32 && s == 8'h05)
      ck(32'(d.no_base_index), 1);
    $display("test done: opcode %h method %0d", ib[0], m);
  endtask : run
  // =====================================
  // main sequence
  initial
  begin
    i_sys_clk     = 1'b0;
    i_rst         = 1'b1;
    i_op_size32   = 1'b1;
    i_addr_size32 = 1'b1;
    i_op_code     = '0;
    i_imm_len     = 3'h0;
    mismatches    = 0;
    checks_done   = 0;
    seed          = 32'h0000_9938;
    repeat (8) @(negedge i_sys_clk);
    ck(32'(o_byte_ready), 0);
    i_rst = 1'b0;
    repeat (2) @(negedge i_sys_clk);
    ck(32'(o_byte_ready), 1);
    run('{8'h03, 8'h05, 8'h00, 8'h00, 8'h00, 8'h00}, AM_RM, OT_VAR,
        3'h0, 1'b1, 1'b1);
    run('{8'h0F, 8'hA4, 8'h05, 8'h00, 8'h00, 8'h00, 8'h00, 8'h03}, AM_RM,
        OT_VAR, 3'h1, 1'b1, 1'b1);
    run('{8'hDD, 8'h05, 8'h04, 8'h00, 8'h00, 8'h00}, AM_NONE, OT_QWORD,
        3'h0, 1'b1, 1'b1);
    run('{8'hD8, 8'hC1}, AM_NONE, OT_QWORD, 3'h0, 1'b1, 1'b0);
    run('{8'hA1, 8'h34, 8'h12}, AM_MOFS, OT_VAR, 3'h0, 1'b0, 1'b0);
    run('{8'hC4, 8'hC3}, AM_MEM, OT_PTR, 3'h0, 1'b1, 1'b1);
    run('{8'h0F, 8'h22, 8'h45}, AM_REGONLY, OT_DWORD, 3'h0, 1'b1,
        1'b1);
    run('{8'h0F, 8'h80, 8'h78, 8'h56}, AM_DIRECT, OT_VAR, 3'h0, 1'b0,
        1'b0);
    for (n = 0; n < 48; n++)
    begin
      rnd = $random(seed);
      op  = (n % 4 == 1) ? 8'h0F : (n % 4 == 2) ? {5'b11011, rnd[18:16]}
                                                : rnd[7:0];
      b = '{op};
      if (op == 8'h0F)
        b.push_back(rnd[15:8]);
      if (hspec(op, addr_method_t'(n % 16)))
        b.push_back(rnd[31:24]);
      repeat (dlen(rnd[31:24], hspec(op, addr_method_t'(n % 16)),
                   addr_method_t'(n % 16), rnd[20]) + n % 5)
        b.push_back(8'($random(seed)));
      fetch_model_inst.gap = n % 3;
      run(b, addr_method_t'(n % 16), op_type_t'(1 + n % 9), 3'(n % 5),
          rnd[20], rnd[21]);
    end
    end_of_test();
  end
  initial
  begin
    #100000;
    mismatches++;
    end_of_test();
  end
endmodule : testbench
`default_nettype wire
